// file: pteu_top.sv
// receive timestamp unit with clock counter and frame event registers
`timescale 1ns/1ps
`default_nettype none
module pteu_top (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // line side pins
  input  wire logic        rx_sfd_pin,
  input  wire logic        ext_lock_trigger_pin,
  // mac parser side
  input  wire logic        frame_done,
  input  wire logic        frame_is_timing,
  input  wire logic [3:0]  frame_msg_type,
  input  wire logic        frame_error,
  output var  logic        timing_frame_detect,
  // system side
  output var  logic [1:0]  timer_clock_select,
  output var  logic        irq
);
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        run;
    logic [1:0]  clk_sel;
    logic        unit_en;
    logic        method;
    logic [1:0]  events;
    logic [1:0]  mask;
    logic [31:0] addend;
    logic [31:0] accum;
    logic [63:0] count;
    logic [63:0] rx_stamp;
    logic [31:0] start_value;
    logic [31:0] interval;
    logic [1:0]  sfd_sync;
    logic [1:0]  trig_sync;
    logic        sfd_last;
    logic        trig_last;
    logic        detect;
    logic        irq;
  } pteu_state_t;

  pteu_state_t cur;
  pteu_state_t nxt;

  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [32:0] acc_sum;
  logic [63:0] step;
  logic        sfd_rise;
  logic        trig_rise;
  logic        is_event_class;
  logic        take_frame;
  logic [1:0]  ev_set;
  logic [1:0]  ev_clr;
  logic [31:0] rd_word;
  // decoded write strobes, one per writable register
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_event;
  logic        wr_mask;
  logic        wr_addend;
  logic        wr_offset;
  logic        wr_start;
  logic        wr_interval;

  always_comb begin
    nxt            = cur;
    setup          = psel && !penable;
    access         = psel && penable && cur.pready;
    wr             = access && pwrite;
    mapped         = 1'b1;
    rd_word        = pteu_pkg::RST_WORD;
    case (paddr)
      pteu_pkg::OFF_CLOCK_CONTROL: rd_word = {29'h0, cur.clk_sel, cur.run};
      pteu_pkg::OFF_STAMP_MODE:    rd_word = {30'h0, cur.method, cur.unit_en};
      pteu_pkg::OFF_FRAME_EVENT:   rd_word = {30'h0, cur.events};
      pteu_pkg::OFF_FRAME_MASK:    rd_word = {30'h0, cur.mask};
      pteu_pkg::OFF_ADDEND:        rd_word = cur.addend;
      pteu_pkg::OFF_COUNT_LOW:     rd_word = cur.count[31:0];
      pteu_pkg::OFF_COUNT_HIGH:    rd_word = cur.count[63:32];
      pteu_pkg::OFF_OFFSET:        rd_word = pteu_pkg::RST_WORD;
      pteu_pkg::OFF_RX_STAMP_LOW:  rd_word = cur.rx_stamp[31:0];
      pteu_pkg::OFF_RX_STAMP_HIGH: rd_word = cur.rx_stamp[63:32];
      pteu_pkg::OFF_START_VALUE:   rd_word = cur.start_value;
      pteu_pkg::OFF_INTERVAL:      rd_word = cur.interval;
      default:                     mapped  = 1'b0;
    endcase
    // one wait-free access phase: ready rises the cycle after setup
    nxt.pready  = setup;
    nxt.pslverr = setup && !mapped;
    // read word taken at setup, cleared after the access so nothing stale lingers
    if (setup && !pwrite) begin
      nxt.prdata = rd_word;
    end else if (access) begin
      nxt.prdata = pteu_pkg::RST_WORD;
    end

    // writes land only at the access edge, never in setup
    wr_ctrl     = wr && (paddr == pteu_pkg::OFF_CLOCK_CONTROL);
    wr_mode     = wr && (paddr == pteu_pkg::OFF_STAMP_MODE);
    wr_event    = wr && (paddr == pteu_pkg::OFF_FRAME_EVENT);
    wr_mask     = wr && (paddr == pteu_pkg::OFF_FRAME_MASK);
    wr_addend   = wr && (paddr == pteu_pkg::OFF_ADDEND);
    wr_offset   = wr && (paddr == pteu_pkg::OFF_OFFSET);
    wr_start    = wr && (paddr == pteu_pkg::OFF_START_VALUE);
    wr_interval = wr && (paddr == pteu_pkg::OFF_INTERVAL);

    if (wr_ctrl) begin
      nxt.run     = pwdata[pteu_pkg::CTRL_RUN_BIT];
      nxt.clk_sel = pwdata[pteu_pkg::CTRL_SEL_LSB +: 2];
    end

    if (wr_mode) begin
      nxt.unit_en = pwdata[pteu_pkg::MODE_EN_BIT];
      nxt.method  = pwdata[pteu_pkg::MODE_METHOD_BIT];
    end

    if (wr_mask) begin
      nxt.mask = pwdata[1:0];
    end

    // new addend steps the accumulator from the next cycle on
    if (wr_addend) begin
      nxt.addend = pwdata;
    end

    // start value and period are only stored; no pulse generator here
    if (wr_start) begin
      nxt.start_value = pwdata;
    end

    if (wr_interval) begin
      nxt.interval = pwdata;
    end

    // accumulator carry advances the counter; offset write adds signed step
    acc_sum = {1'b0, cur.accum} + {1'b0, cur.addend};
    step    = 64'h0;
    if (cur.run) begin
      nxt.accum = acc_sum[31:0];
      step      = {63'h0, acc_sum[32]};
    end
    if (wr_offset) begin
      step = step + {{32{pwdata[31]}}, pwdata};
    end
    nxt.count = cur.count + step;

    // line pins pass two flops; only the second stage is read
    // edge history resets low like an idle pin, so reset makes no false edge
    nxt.sfd_sync  = {cur.sfd_sync[0], rx_sfd_pin};
    nxt.trig_sync = {cur.trig_sync[0], ext_lock_trigger_pin};
    nxt.sfd_last  = cur.sfd_sync[1];
    nxt.trig_last = cur.trig_sync[1];
    sfd_rise      = cur.sfd_sync[1] && !cur.sfd_last;
    trig_rise     = cur.trig_sync[1] && !cur.trig_last;
    if (cur.unit_en && (sfd_rise || trig_rise)) begin
      // stamp taken back by the receive delay to the line point
      nxt.rx_stamp = cur.count - 64'(pteu_pkg::RX_CAPTURE_DELAY);
    end

    case (frame_msg_type)
      pteu_pkg::MSG_SYNC,
      pteu_pkg::MSG_DELAY_REQ,
      pteu_pkg::MSG_PDELAY_REQ,
      pteu_pkg::MSG_PDELAY_RESP: is_event_class = 1'b1;
      default:                   is_event_class = 1'b0;
    endcase
    take_frame     = cur.unit_en && frame_done && frame_is_timing && is_event_class;
    nxt.detect     = take_frame;

    // an errored frame still reaches the mac but sets no event
    ev_set         = 2'h0;
    if (take_frame && !frame_error) begin
      ev_set[pteu_pkg::EV_RX_BIT]  = 1'b1;
      ev_set[pteu_pkg::EV_OVR_BIT] = cur.events[pteu_pkg::EV_RX_BIT];
    end
    ev_clr = 2'h0;
    if (wr_event) begin
      ev_clr = pwdata[1:0] & pteu_pkg::EV_IMPL_MASK;
    end
    // set wins over a clear in the same cycle
    nxt.events = (cur.events & ~ev_clr) | ev_set;
    nxt.irq    = |(nxt.events & nxt.mask);
  end

  // start value parks at all ones, every other field clears
  always_ff @(posedge clk) begin
    if (srst) begin
      cur             <= '0;
      cur.clk_sel     <= pteu_pkg::RST_CLK_SEL;
      cur.addend      <= pteu_pkg::RST_WORD;
      cur.start_value <= pteu_pkg::RST_ALL_ONES;
      cur.interval    <= pteu_pkg::RST_WORD;
    end else if (ce) begin
      cur <= nxt;
    end
  end

  // every output comes straight from a state flop
  assign prdata              = cur.prdata;
  assign pready              = cur.pready;
  assign pslverr             = cur.pslverr;
  assign timing_frame_detect = cur.detect;
  assign timer_clock_select  = cur.clk_sel;
  assign irq                 = cur.irq;
endmodule : pteu_top
`default_nettype wire

// file: pteu_pkg.sv
// constants of the receive timestamp and event unit
package pteu_pkg;
  localparam logic [7:0]  OFF_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0]  OFF_STAMP_MODE    = 8'h04;
  localparam logic [7:0]  OFF_FRAME_EVENT   = 8'h08;
  localparam logic [7:0]  OFF_FRAME_MASK    = 8'h0C;
  localparam logic [7:0]  OFF_ADDEND        = 8'h10;
  localparam logic [7:0]  OFF_COUNT_LOW     = 8'h14;
  localparam logic [7:0]  OFF_COUNT_HIGH    = 8'h18;
  localparam logic [7:0]  OFF_OFFSET        = 8'h1C;
  localparam logic [7:0]  OFF_RX_STAMP_LOW  = 8'h20;
  localparam logic [7:0]  OFF_RX_STAMP_HIGH = 8'h24;
  localparam logic [7:0]  OFF_START_VALUE   = 8'h28;
  localparam logic [7:0]  OFF_INTERVAL      = 8'h2C;
  // clock control fields
  localparam int          CTRL_RUN_BIT      = 0;
  localparam int          CTRL_SEL_LSB      = 1;
  // stamp mode fields
  localparam int          MODE_EN_BIT       = 0;
  localparam int          MODE_METHOD_BIT   = 1;
  // frame event fields
  localparam int          EV_RX_BIT         = 0;
  localparam int          EV_OVR_BIT        = 1;
  localparam logic [1:0]  EV_IMPL_MASK      = 2'h3;
  // timing message types of the event class
  localparam logic [3:0]  MSG_SYNC          = 4'h0;
  localparam logic [3:0]  MSG_DELAY_REQ     = 4'h1;
  localparam logic [3:0]  MSG_PDELAY_REQ    = 4'h2;
  localparam logic [3:0]  MSG_PDELAY_RESP   = 4'h3;
  // reset values
  localparam logic [31:0] RST_WORD          = 32'h0000_0000;
  localparam logic [31:0] RST_ALL_ONES      = 32'hFFFF_FFFF;
  localparam logic [1:0]  RST_CLK_SEL       = 2'h0;
  // receive capture delay, counter ticks taken off the count at the delimiter
  localparam int          RX_CAPTURE_DELAY  = 1;
endpackage : pteu_pkg

// file: pteu_sva.sv
// concurrent checks at the timestamp unit ports
`timescale 1ns/1ps
`default_nettype none
module pteu_sva (
  // clock, reset and bus
  input wire logic       clk, srst, ce, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  // frame side and system side
  input wire logic       frame_done, frame_is_timing, frame_error, timing_frame_detect, irq,
  input wire logic [3:0] frame_msg_type,
  input wire logic [1:0] timer_clock_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  rdy_after_setup_a: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
  rdy_one_cycle_a: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (pready && paddr > 8'h2C |-> pslverr)
    else $error("unmapped access without error");
  detect_cause_a: assert property (timing_frame_detect && $past(ce) |->
    $past(frame_done && frame_is_timing && frame_msg_type < 4'h4)) else $error("stray detect");
  general_class_a: assert property (ce && frame_done &&
    (!frame_is_timing || frame_msg_type > 4'h3) |=> !timing_frame_detect) else $error("bad detect");
  irq_fall_a: assert property ($fell(irq) |-> $past(srst) || $past(pready && pwrite &&
    (paddr == pteu_pkg::OFF_FRAME_EVENT || paddr == pteu_pkg::OFF_FRAME_MASK)))
    else $error("irq dropped without write");
  irq_rise_a: assert property ($rose(irq) |-> $past(frame_done) ||
    $past(pready && pwrite && paddr == pteu_pkg::OFF_FRAME_MASK)) else $error("irq without cause");
  clk_sel_a: assert property ($changed(timer_clock_select) |-> $past(srst) ||
    $past(pready && pwrite && paddr == pteu_pkg::OFF_CLOCK_CONTROL)) else $error("select moved");
endmodule : pteu_sva
`default_nettype wire

// file: pteu_mac_model.sv
// frame parser stand-in on the mac side
`timescale 1ns/1ps
`default_nettype none
module pteu_mac_model (
  // clock and answer
  input  wire logic       clk,
  input  wire logic       timing_frame_detect,
  // frame end pulse and qualifiers
  output var  logic       frame_done = 1'b0,
  output var  logic       frame_is_timing = 1'b0,
  output var  logic [3:0] frame_msg_type = 4'hF,
  output var  logic       frame_error = 1'b1
);
  int n_detect = 0;
  always @(posedge clk) if (timing_frame_detect) n_detect++;
  // qualifiers scrambled between frames
  task automatic send(input logic [3:0] t, input logic e, input int gap);
    repeat (gap + 1) @(posedge clk);
    {frame_done, frame_is_timing, frame_msg_type, frame_error} <= {2'b11, t, e};
    @(posedge clk);
    {frame_done, frame_is_timing, frame_msg_type, frame_error} <= {2'b00, ~t, ~e};
  endtask : send
endmodule : pteu_mac_model
`default_nettype wire

// file: pteu_top_test.sv
// self-checking bench for the receive timestamp unit
`timescale 1ns/1ps
`default_nettype none
module pteu_top_test;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, sfd = 1'b0, trig = 1'b0, fdone, ftim, ferr, det, irq;
  logic [3:0]  ftype;
  logic [1:0]  csel;
  int          n_mismatch = 0, n_checks = 0;
  always #2 clk = ~clk;
  pteu_top pteu_top_inst (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_sfd_pin(sfd), .ext_lock_trigger_pin(trig), .frame_done(fdone),
    .frame_is_timing(ftim), .frame_msg_type(ftype), .frame_error(ferr),
    .timing_frame_detect(det), .timer_clock_select(csel), .irq(irq));
  pteu_mac_model pteu_mac_model_inst (.clk(clk), .timing_frame_detect(det), .frame_done(fdone),
    .frame_is_timing(ftim), .frame_msg_type(ftype), .frame_error(ferr));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin n_mismatch++; test_done(); end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  // pin held high past the synchroniser, then low
  task automatic pulse(input logic use_trig);
    {trig, sfd} <= use_trig ? 2'b10 : 2'b01;
    repeat (4) @(posedge clk);
    {trig, sfd} <= 2'b00;
    repeat (3) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    apb(0, pteu_pkg::OFF_START_VALUE, 0); chk(rd, 32'hFFFF_FFFF);
    apb(0, 8'h30, 32'h0); chk(err, 1'b1); chk(rd, 32'h0);
    apb(1, pteu_pkg::OFF_START_VALUE, 32'hFFFF_FFFF);
    apb(1, pteu_pkg::OFF_INTERVAL, 32'h0000_0040);
    apb(0, pteu_pkg::OFF_INTERVAL, 0); chk(rd, 32'h0000_0040);
    $display("test bus done");
    apb(1, pteu_pkg::OFF_STAMP_MODE, 32'h2);
    apb(1, pteu_pkg::OFF_FRAME_MASK, 32'h1);
    apb(1, pteu_pkg::OFF_FRAME_EVENT, 32'hFFFF_FFFF);
    apb(1, pteu_pkg::OFF_CLOCK_CONTROL, 32'h7);
    apb(1, pteu_pkg::OFF_STAMP_MODE, 32'h3);
    @(negedge clk); chk(csel, 2'h3);
    for (int t = 0; t < 6; t++) begin
      pteu_mac_model_inst.send(t[3:0], 1'b0, t);
      apb(0, pteu_pkg::OFF_FRAME_EVENT, 0); chk(rd, {31'h0, t < 4});
      @(negedge clk); chk(irq, t < 4);
      apb(1, pteu_pkg::OFF_FRAME_EVENT, 32'h1);
    end
    pteu_mac_model_inst.send(4'h0, 1'b0, 0);
    pteu_mac_model_inst.send(4'h3, 1'b0, 0);
    apb(0, pteu_pkg::OFF_FRAME_EVENT, 0); chk(rd, 32'h3);
    apb(1, pteu_pkg::OFF_FRAME_EVENT, 32'h0);
    apb(0, pteu_pkg::OFF_FRAME_EVENT, 0); chk(rd, 32'h3);
    apb(1, pteu_pkg::OFF_FRAME_EVENT, 32'h1);
    apb(0, pteu_pkg::OFF_FRAME_EVENT, 0); chk(rd, 32'h2);
    @(negedge clk); chk(irq, 1'b0);
    apb(1, pteu_pkg::OFF_FRAME_MASK, 32'h3);
    @(negedge clk); chk(irq, 1'b1);
    apb(1, pteu_pkg::OFF_FRAME_EVENT, 32'h2);
    pteu_mac_model_inst.send(4'h2, 1'b1, 1);
    apb(0, pteu_pkg::OFF_FRAME_EVENT, 0); chk(irq, 1'b0); chk(rd, 32'h0);
    ce <= 1'b0;
    pteu_mac_model_inst.send(4'h0, 1'b0, 0);
    ce <= 1'b1;
    apb(0, pteu_pkg::OFF_FRAME_EVENT, 0); chk(rd, 32'h0);
    chk(pteu_mac_model_inst.n_detect, 32'd7);
    $display("test frames done");
    apb(1, pteu_pkg::OFF_OFFSET, 32'h100);
    apb(0, pteu_pkg::OFF_COUNT_LOW, 0); chk(rd, 32'h100);
    pulse(1'b0);
    apb(0, pteu_pkg::OFF_RX_STAMP_LOW, 0); chk(rd, 32'hFF);
    apb(1, pteu_pkg::OFF_OFFSET, 32'hFFFF_FFF0);
    apb(0, pteu_pkg::OFF_COUNT_HIGH, 0); chk(rd, 32'h0);
    apb(0, pteu_pkg::OFF_COUNT_LOW, 0); chk(rd, 32'hF0);
    pulse(1'b1);
    apb(0, pteu_pkg::OFF_RX_STAMP_LOW, 0); chk(rd, 32'hEF);
    $display("test capture done");
    apb(1, pteu_pkg::OFF_ADDEND, 32'hFFFF_FFFF);
    apb(0, pteu_pkg::OFF_COUNT_LOW, 0); chk(rd, 32'hF0);
    apb(0, pteu_pkg::OFF_COUNT_LOW, 0); chk(rd, 32'hF3);
    apb(1, pteu_pkg::OFF_CLOCK_CONTROL, 32'h6);
    apb(0, pteu_pkg::OFF_COUNT_LOW, 0); chk(rd, 32'hF8);
    apb(0, pteu_pkg::OFF_COUNT_LOW, 0); chk(rd, 32'hF8);
    $display("test clock done");
    test_done();
  end
endmodule : pteu_top_test
bind pteu_top pteu_sva pteu_sva_inst (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .frame_done(frame_done), .frame_is_timing(frame_is_timing), .frame_error(frame_error),
  .timing_frame_detect(timing_frame_detect), .irq(irq), .frame_msg_type(frame_msg_type),
  .timer_clock_select(timer_clock_select));
`default_nettype wire
